// file: core/octal_driver_serial_control.sv
// Serial control, output latch and fault blanking of an octal low-side driver.
`timescale 1ns/1ns
module octal_driver_serial_control #(
  parameter int unsigned FAULT_BLANK_CYCLES = octal_drv_pkg::FAULT_BLANK_DELAY_CYC
) (
  // Clock and resets.
  input  wire logic                                 CLK_IN,
  input  wire logic                                 RST_IN,
  input  wire logic                                 RESET_N_IN,
  // Serial link pins.
  input  wire logic                                 CE_N_IN,
  input  wire logic                                 SCLK_IN,
  input  wire logic                                 SI_IN,
  output logic                                      SO_OUT,
  output logic                                      SO_OE_OUT,
  // Output stages and their comparators.
  input  wire logic [octal_drv_pkg::CHANNELS-1:0]   SENSE_HIGH_IN,
  output logic      [octal_drv_pkg::CHANNELS-1:0]   LOAD_OFF_OUT,
  // Status.
  output logic                                      BLANKING_OUT,
  output logic                                      BUF_READY_OUT
);
  import octal_drv_pkg::*;

  localparam logic [BLANK_CNT_WIDTH-1:0] BLANK_LOAD = BLANK_CNT_WIDTH'(FAULT_BLANK_CYCLES);

  // A level counts only once the second and third stages agree.
  function automatic logic [SYNC_WIDTH-1:0] settle(input logic [SYNC_WIDTH-1:0] s2,
                                                  input logic [SYNC_WIDTH-1:0] s3,
                                                  input logic [SYNC_WIDTH-1:0] lvl);
    settle = (s2 & s3) | (lvl & (s2 ^ s3));
  endfunction : settle

  function automatic logic ptr_next(input logic p);
    ptr_next = ~p;
  endfunction : ptr_next

  //////////////////////////////////////////////////////////////////////////////
  logic [SYNC_WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
  logic                  ce_n, sclk, si, ce_n_prev_q, sclk_prev_q;
  logic [CHANNELS-1:0]   sense;
  logic                  ce_fall, ce_rise, sclk_rise, sclk_fall, selected;
  link_e                 link_q;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      s1_q <= SYNC_RESET;
      s2_q <= SYNC_RESET;
      s3_q <= SYNC_RESET;
      lvl_q <= SYNC_RESET;
      ce_n_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else if (RST_IN) begin
      s1_q <= SYNC_RESET;
      s2_q <= SYNC_RESET;
      s3_q <= SYNC_RESET;
      lvl_q <= SYNC_RESET;
      ce_n_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      s1_q <= {CE_N_IN, SCLK_IN, SI_IN, SENSE_HIGH_IN};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      ce_n_prev_q <= ce_n;
      sclk_prev_q <= sclk;
    end
  end

  assign lvl_d = settle(s2_q, s3_q, lvl_q);
  assign ce_n = lvl_q[SYNC_CE_POS];
  assign sclk = lvl_q[SYNC_SCLK_POS];
  assign si = lvl_q[SYNC_SI_POS];
  assign sense = lvl_q[CHANNELS-1:0];
  assign ce_fall = ce_n_prev_q & ~ce_n;
  assign ce_rise = ~ce_n_prev_q & ce_n;
  // The clock is gated by the enable, so no edge counts while deselected.
  assign selected = (link_q == LINK_SHIFT) & ~ce_n;
  assign sclk_rise = selected & ~sclk_prev_q & sclk;
  assign sclk_fall = selected & sclk_prev_q & ~sclk;

  //////////////////////////////////////////////////////////////////////////////
  logic [CHANNELS-1:0] shift_q;
  logic                so_q, so_oe_q;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      link_q <= LINK_IDLE;
    end else if (RST_IN) begin
      link_q <= LINK_IDLE;
    end else begin
      case (link_q)
        LINK_IDLE: begin
          if (ce_fall) begin
            link_q <= LINK_SHIFT;
          end
        end
        LINK_SHIFT: begin
          if (ce_rise) begin
            link_q <= LINK_COMMIT;
          end
        end
        LINK_COMMIT: begin
          link_q <= ce_fall ? LINK_SHIFT : LINK_IDLE;
        end
        default: begin
          link_q <= LINK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      shift_q <= SHIFT_RESET;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (RST_IN) begin
      shift_q <= SHIFT_RESET;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      so_oe_q <= ~ce_n;
      if (ce_fall) begin
        shift_q <= sense;
      end else if (sclk_fall) begin
        shift_q <= {shift_q[CHANNELS-2:0], si};
      end
      if (sclk_rise) begin
        so_q <= shift_q[CHANNELS-1];
      end
    end
  end

  assign SO_OUT = so_q;
  assign SO_OE_OUT = so_oe_q;

  //////////////////////////////////////////////////////////////////////////////
  // A byte committed while the previous one still waits is held, not lost.
  logic [CHANNELS-1:0] buf_q [BUF_DEPTH];
  logic                wr_ptr_q, rd_ptr_q;
  logic [1:0]          buf_cnt_q;
  logic                push, pop, in_ready, out_valid, out_ready, fault_hit;
  logic [CHANNELS-1:0] latch_q, fault_bits;
  logic [BLANK_CNT_WIDTH-1:0] blank_cnt_q;

  assign in_ready = (buf_cnt_q != 2'(BUF_DEPTH));
  assign push = ce_rise & in_ready;
  assign out_valid = (buf_cnt_q != 2'h0);
  assign fault_bits = ~latch_q & sense;
  assign fault_hit = (blank_cnt_q == '0) & (|fault_bits);
  // A fault clear takes the latch for one cycle and stalls the drain.
  assign out_ready = ~fault_hit;
  assign pop = out_valid & out_ready;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      buf_cnt_q <= BUF_COUNT_RESET;
      buf_q[0] <= LATCH_RESET;
      buf_q[1] <= LATCH_RESET;
    end else if (RST_IN) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      buf_cnt_q <= BUF_COUNT_RESET;
    end else begin
      if (push) begin
        buf_q[wr_ptr_q] <= shift_q;
        wr_ptr_q <= ptr_next(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= ptr_next(rd_ptr_q);
      end
      buf_cnt_q <= 2'(buf_cnt_q + {1'b0, push} - {1'b0, pop});
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      blank_cnt_q <= '0;
    end else if (RST_IN) begin
      blank_cnt_q <= '0;
    end else if (ce_rise) begin
      blank_cnt_q <= BLANK_LOAD;
    end else if (blank_cnt_q != '0) begin
      blank_cnt_q <= blank_cnt_q - 1'b1;
    end
  end

  // Latch bit one means off, so a zero control bit switches the load on.
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      latch_q <= LATCH_RESET;
    end else if (RST_IN) begin
      latch_q <= LATCH_RESET;
    end else if (pop) begin
      latch_q <= buf_q[rd_ptr_q];
    end else if (fault_hit) begin
      latch_q <= latch_q | fault_bits;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      BLANKING_OUT <= 1'b0;
      BUF_READY_OUT <= 1'b1;
    end else if (RST_IN) begin
      BLANKING_OUT <= 1'b0;
      BUF_READY_OUT <= 1'b1;
    end else begin
      BLANKING_OUT <= (blank_cnt_q != '0) | ce_rise;
      BUF_READY_OUT <= (buf_cnt_q + {1'b0, push} - {1'b0, pop}) != 2'(BUF_DEPTH);
    end
  end

  assign LOAD_OFF_OUT = latch_q;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN || !RESET_N_IN);

  so_enable_a: assert property (SO_OE_OUT == !$past(ce_n))
    else $error("serial output not driven while selected");
  diag_load_a: assert property (ce_fall |=> shift_q == $past(sense))
    else $error("diagnostic bits not loaded at enable fall");
  first_bit_a: assert property (sclk_rise |=> SO_OUT == $past(shift_q[CHANNELS-1]))
    else $error("serial output does not show top shift bit");
  shift_in_a: assert property (sclk_fall && !ce_fall |=>
    shift_q == {$past(shift_q[CHANNELS-2:0]), $past(si)})
    else $error("serial input not captured on clock fall");
  clock_ignored_a: assert property (ce_n && !ce_fall |=> $stable(shift_q) && $stable(SO_OUT))
    else $error("shift register moved while deselected");
  timer_start_a: assert property (ce_rise |=> blank_cnt_q == BLANK_LOAD ##1 BLANKING_OUT)
    else $error("blanking timer not started at enable rise");
  no_clear_a: assert property (blank_cnt_q != '0 && !pop |=> latch_q == $past(latch_q))
    else $error("latch cleared by fault during blanking");
  fault_off_a: assert property (fault_hit && !pop |=> (latch_q & $past(fault_bits)) ==
    $past(fault_bits))
    else $error("faulted output not switched off after blanking");
  latch_load_a: assert property (push && buf_cnt_q == 2'h0 |=> ##1 latch_q == $past(shift_q, 2))
    else $error("committed byte did not reach the latch");

  fault_seen_c: cover property (fault_hit ##1 (latch_q != $past(latch_q)));
  two_bytes_c: cover property (buf_cnt_q == 2'(BUF_DEPTH));
  byte_sent_c: cover property (ce_fall ##[1:400] sclk_fall ##[1:400] ce_rise);
  blank_done_c: cover property (blank_cnt_q == 14'h0001 ##1 blank_cnt_q == '0);

endmodule : octal_driver_serial_control

// file: core/octal_drv_pkg.sv
// Constants shared by the octal driver serial control logic.
package octal_drv_pkg;

  localparam int unsigned CHANNELS = 8;
  localparam int unsigned SYNC_WIDTH = 11;

  // Clock rate and the fault blanking delay in its own unit.
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned FAULT_BLANK_DELAY_US = 160;
  localparam int unsigned FAULT_BLANK_DELAY_CYC = FAULT_BLANK_DELAY_US * CLK_MHZ;
  localparam int unsigned BLANK_CNT_WIDTH = 14;

  // Bit positions inside the synchroniser vector.
  localparam int unsigned SYNC_CE_POS = 10;
  localparam int unsigned SYNC_SCLK_POS = 9;
  localparam int unsigned SYNC_SI_POS = 8;

  // Values after reset: chip enable idle high, clock low, every output off.
  localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 11'h400;
  localparam logic [CHANNELS-1:0] LATCH_RESET = 8'hFF;
  localparam logic [CHANNELS-1:0] SHIFT_RESET = 8'h00;

  // Two-entry buffer between the shift register and the parallel latch.
  localparam int unsigned BUF_DEPTH = 2;
  localparam logic [1:0] BUF_COUNT_RESET = 2'h0;

  typedef enum logic [1:0] {
    LINK_IDLE   = 2'b00,
    LINK_SHIFT  = 2'b01,
    LINK_COMMIT = 2'b11
  } link_e;

endpackage : octal_drv_pkg

// file: sim/spi_master_model.sv
// Behavioural SPI master that drives the serial link of the octal driver.
`timescale 1ns/1ns
module spi_master_model (
  // Pacing clock.
  input  wire logic clk_in,
  // Link pins.
  input  wire logic so_in,
  input  wire logic so_oe_in,
  output logic      ce_n_out,
  output logic      sclk_out,
  output logic      si_out
);
  logic oe_ok;

  initial begin
    ce_n_out = 1'b1;
    sclk_out = 1'b0;
    si_out = 1'b1;
    oe_ok = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : wait_clk

  ////////////////////////////////////////////////////////////////////////////////
  // Serial out is sampled late in the low phase, since it settles some cycles after the rise.
  task automatic xfer(input int nbits, input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    oe_ok = 1'b1;
    wait_clk(1);
    ce_n_out = 1'b0;
    wait_clk(8);
    for (int i = nbits - 1; i >= 0; i--) begin
      si_out = tx[i];
      sclk_out = 1'b1;
      wait_clk(4);
      sclk_out = 1'b0;
      wait_clk(3);
      rx = {rx[14:0], so_in};
      oe_ok = oe_ok & so_oe_in;
      wait_clk(1);
    end
    wait_clk(8);
    ce_n_out = 1'b1;
    si_out = ~si_out;
    wait_clk(8);
  endtask : xfer

  task automatic stray_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      sclk_out = 1'b1;
      wait_clk(4);
      sclk_out = 1'b0;
      wait_clk(4);
    end
  endtask : stray_clocks
endmodule : spi_master_model

// file: sim/test_octal_driver_serial_control.sv
// Self-checking bench for the octal driver serial control block.
`timescale 1ns/1ns
module test_octal_driver_serial_control;
  localparam int unsigned BLANK = 100;
  logic        CLK_IN;
  logic        RST_IN;
  logic        RESET_N_IN;
  logic [7:0]  short_mask;
  logic [7:0]  open_mask;
  logic [15:0] rx;
  wire         ce_n;
  wire         sclk;
  wire         si;
  wire         so;
  wire         so_oe;
  wire         blanking;
  wire         buf_ready;
  wire  [7:0]  load_off;
  wire  [7:0]  sense;
  int          bad_count;
  int          check_count;
  int          cyc;

  // Load model: an off output is pulled high, unless open; a short keeps it high.
  assign sense = (load_off & ~open_mask) | short_mask;

  octal_driver_serial_control #(.FAULT_BLANK_CYCLES(BLANK)) dut_u (
    .CLK_IN(CLK_IN), .RST_IN(RST_IN), .RESET_N_IN(RESET_N_IN), .CE_N_IN(ce_n),
    .SCLK_IN(sclk), .SI_IN(si), .SO_OUT(so), .SO_OE_OUT(so_oe), .SENSE_HIGH_IN(sense),
    .LOAD_OFF_OUT(load_off), .BLANKING_OUT(blanking), .BUF_READY_OUT(buf_ready));

  spi_master_model master_u (.clk_in(CLK_IN), .so_in(so_oe ? so : 1'bz), .so_oe_in(so_oe),
    .ce_n_out(ce_n), .sclk_out(sclk), .si_out(si));

  initial begin
    CLK_IN = 1'b0;
    forever #10 CLK_IN = ~CLK_IN;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wait_clk(input int n);
    repeat (n) @(posedge CLK_IN);
    #1;
  endtask : wait_clk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  always @(posedge CLK_IN) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    chk("latch", 16'h00FF, {8'h00, load_off});
    chk("so_oe", 16'h0000, {15'h0000, so_oe});
    chk("blanking", 16'h0000, {15'h0000, blanking});
    chk("buf_ready", 16'h0001, {15'h0000, buf_ready});
    $display("test reset done");
  endtask : test_reset

  task automatic test_write_read();
    master_u.xfer(8, 16'h00A5, rx);
    wait_clk(4);
    chk("latch", 16'h00A5, {8'h00, load_off});
    chk("blanking", 16'h0001, {15'h0000, blanking});
    chk("so_oe", 16'h0001, {15'h0000, master_u.oe_ok});
    master_u.xfer(8, 16'h00A5, rx);
    chk("diag", 16'h00A5, {8'h00, rx[7:0]});
    $display("test write read done");
  endtask : test_write_read

  task automatic test_chain();
    master_u.xfer(16, 16'h3C81, rx);
    chk("chain", 16'hA53C, rx);
    wait_clk(4);
    chk("latch", 16'h0081, {8'h00, load_off});
    master_u.stray_clocks(8);
    wait_clk(4);
    chk("latch", 16'h0081, {8'h00, load_off});
    chk("so_oe", 16'h0000, {15'h0000, so_oe});
    $display("test chain done");
  endtask : test_chain

  // A short on output 2 and an open load on output 5.
  task automatic test_fault();
    short_mask = 8'h04;
    open_mask = 8'h20;
    master_u.xfer(8, 16'h0020, rx);
    wait_clk(4);
    chk("latch", 16'h0020, {8'h00, load_off});
    wait_clk(120);
    chk("latch", 16'h0024, {8'h00, load_off});
    master_u.xfer(8, 16'h0020, rx);
    chk("diag", 16'h0004, {8'h00, rx[7:0]});
    wait_clk(120);
    short_mask = 8'h00;
    open_mask = 8'h00;
    $display("test fault done");
  endtask : test_fault

  task automatic test_restart();
    master_u.xfer(8, 16'h00FF, rx);
    master_u.xfer(8, 16'h00FF, rx);
    wait_clk(90);
    chk("blanking", 16'h0001, {15'h0000, blanking});
    wait_clk(20);
    chk("blanking", 16'h0000, {15'h0000, blanking});
    $display("test restart done");
  endtask : test_restart

  task automatic test_async_reset();
    master_u.xfer(8, 16'h0000, rx);
    wait_clk(4);
    RESET_N_IN = 1'b0;
    #5;
    chk("latch", 16'h00FF, {8'h00, load_off});
    chk("blanking", 16'h0000, {15'h0000, blanking});
    wait_clk(2);
    RESET_N_IN = 1'b1;
    wait_clk(4);
    chk("latch", 16'h00FF, {8'h00, load_off});
    $display("test async reset done");
  endtask : test_async_reset

  initial begin
    RST_IN = 1'b1;
    RESET_N_IN = 1'b1;
    short_mask = 8'h00;
    open_mask = 8'h00;
    repeat (6) @(posedge CLK_IN);
    #1;
    RST_IN = 1'b0;
    wait_clk(2);
    test_reset();
    test_write_read();
    test_chain();
    test_fault();
    test_restart();
    test_async_reset();
    stop_test();
  end
endmodule : test_octal_driver_serial_control
